// ### core/dfs_pkg.sv
// constants shared by the drive fault supervisor and its timers
package dfs_pkg;
  // clock rate and derived timing
  localparam int CLK_KHZ        = 25_000;                 // 25 MHz hclk
  localparam int HOLD_MS        = 1500;                   // power-up hold, ms
  localparam int HOLD_CYCLES    = HOLD_MS * CLK_KHZ;      // hold length in cycles
  localparam int TICK_MS        = 1000;                   // overload timer tick, ms
  localparam int TICK_CYCLES    = TICK_MS * CLK_KHZ;      // tick period in cycles
  localparam int OVL_FULL_S     = 60;                     // overload full scale, s
  localparam int OVL_FULL_TICKS = OVL_FULL_S * 1000 / TICK_MS;
  localparam int CNT_W          = 26;                     // wide enough for both prescalers
  localparam int OVL_W          = 6;                      // overload count width
  localparam logic [OVL_W-1:0] OVL_FULL = OVL_W'(OVL_FULL_TICKS);

  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;              // sticky events, read only
  localparam logic [7:0] OFF_CLEAR  = 8'h04;              // write 1 to clear status
  localparam logic [7:0] OFF_ENABLE = 8'h08;              // interrupt enables
  localparam logic [7:0] OFF_FAULTS = 8'h0C;              // live fault and lamp state
  localparam logic [7:0] OFF_CTRL   = 8'h10;              // bit 0 fault reset pulse
  localparam logic [7:0] OFF_OVLCNT = 8'h14;              // overload accumulation

  // event and fault-state bit positions
  localparam int NEV         = 12;
  localparam int EV_LINE_LOW = 0;
  localparam int EV_BUS_HIGH = 1;
  localparam int EV_LEG      = 2;
  localparam int EV_EARTH    = 3;
  localparam int EV_PEAK     = 4;
  localparam int EV_SUST     = 5;
  localparam int EV_THERMAL  = 6;
  localparam int EV_OPTION   = 7;
  localparam int EV_REGEN    = 8;
  localparam int EV_LOCKOUT  = 9;
  localparam int EV_HOLD     = 10;
  localparam int EV_OVL_LAMP = 11;

  // trip latch positions
  localparam int NTRIP = 7;
  localparam int TR_BUS_HIGH = 0;
  localparam int TR_LEG      = 1;
  localparam int TR_EARTH    = 2;
  localparam int TR_PEAK     = 3;
  localparam int TR_SUST     = 4;
  localparam int TR_THERMAL  = 5;
  localparam int TR_OPTION   = 6;

  // control bit and reset values
  localparam int CTRL_FAULT_RESET = 0;
  localparam logic [NEV-1:0] ENABLE_RST = 12'h000;
  localparam logic [1:0]     LOCK_SECOND = 2'h2;          // lockout count for two faults
endpackage

// ### core/dfs_ovl_if.sv
// link between supervisor and the overload accumulation timer
`timescale 1ns/100ps
`default_nettype none
interface dfs_ovl_if;
  logic                     above;  // current above overload level
  logic                     full;   // accumulation at full scale
  logic [dfs_pkg::OVL_W-1:0] count; // present accumulation
  modport timer (input above, output full, output count);
  modport sup   (output above, input full, input count);
endinterface
`default_nettype wire

// ### core/dfs_hold_timer.sv
// power-up hold timer: high from reset for a fixed number of cycles
`timescale 1ns/100ps
`default_nettype none
module dfs_hold_timer #(
  parameter int HOLD_CYCLES = dfs_pkg::HOLD_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      hold
);
  logic [dfs_pkg::CNT_W-1:0] cnt_q;  // cycles spent in hold
  logic                      hold_q; // hold active

  // count from reset release, drop hold on the last cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      hold_q <= 1'b1;
    end else if (hold_q) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == dfs_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
        hold_q <= 1'b0;
      end
    end
  end

  assign hold = hold_q;
endmodule
`default_nettype wire

// ### core/dfs_ovl_timer.sv
// overload accumulation timer: saturating up/down count on a fixed tick
`timescale 1ns/100ps
`default_nettype none
module dfs_ovl_timer #(
  parameter int TICK_CYCLES = dfs_pkg::TICK_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  dfs_ovl_if.timer  ovl
);
  logic [dfs_pkg::CNT_W-1:0] pre_q;  // tick prescaler
  logic                      tick;   // one cycle per tick period
  logic [dfs_pkg::OVL_W-1:0] acc_q;  // accumulated above-level time

  assign tick = (pre_q == dfs_pkg::CNT_W'(TICK_CYCLES - 1));

  // free-running tick prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // up while above, down at same rate while below; only power loss clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
    end else if (tick) begin
      if (ovl.above && acc_q != dfs_pkg::OVL_FULL) begin
        acc_q <= acc_q + 1'b1;
      end else if (!ovl.above && acc_q != '0) begin
        acc_q <= acc_q - 1'b1;
      end
    end
  end

  assign ovl.full  = (acc_q == dfs_pkg::OVL_FULL);
  assign ovl.count = acc_q;
endmodule
`default_nettype wire

// ### core/dfs_supervisor.sv
// drive fault supervisor: fault latches, lamps, lockout and AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module dfs_supervisor #(
  parameter int TICK_CYCLES = dfs_pkg::TICK_CYCLES,
  parameter int HOLD_CYCLES = dfs_pkg::HOLD_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // comparator and sensor inputs
  input  wire logic        line_below_low,
  input  wire logic        line_above_high,
  input  wire logic        bus_above_hi_class,
  input  wire logic        bus_above_lo_class,
  input  wire logic        bus_below_hi_class,
  input  wire logic        bus_below_lo_class,
  input  wire logic        earth_current,
  input  wire logic        current_at_peak,
  input  wire logic        current_above_level,
  input  wire logic        over_temperature,
  input  wire logic        cooling_air_lost,
  input  wire logic        precharge_failed,
  input  wire logic        option_fault_in,
  input  wire logic        regen_flow,
  // selections, strap and reset button
  input  wire logic        bus_voltage_class_select,
  input  wire logic        option_lockout_select,
  input  wire logic        lockout_count_strap,
  input  wire logic        fault_reset,
  // lamps and run path
  output logic             line_low_flag,
  output logic             bus_high_fault,
  output logic             leg_conduction_fault,
  output logic             earth_leak_fault,
  output logic             peak_current_trip,
  output logic             sustained_overcurrent_fault,
  output logic             overcurrent_timer_lamp,
  output logic             thermal_precharge_fault,
  output logic             option_fault,
  output logic             powerup_hold,
  output logic             drive_lockout_lamp,
  output logic             regen_lamp,
  output logic             drive_run_enable,
  output logic             irq
);
  dfs_ovl_if ovl ();

  logic                      hold;        // power-up hold from timer
  logic                      uv_q;        // undervoltage flag with hysteresis
  logic                      lamp_q;      // overload timer lamp
  logic                      regen_q;     // regeneration lamp
  logic                      opt_in_q;    // option fault indication
  logic [dfs_pkg::NTRIP-1:0] trip_set;    // trip conditions this cycle
  logic [dfs_pkg::NTRIP-1:0] trip_q;      // latched trips
  logic                      rst_all;     // fault reset from pin or register
  logic                      ctrl_rst_q;  // register fault reset pulse
  logic                      strap_q;     // lockout count strap, caught once
  logic                      armed_q;     // strap captured
  logic [1:0]                nfault_q;    // trip events since reset
  logic                      new_trip;    // a trip latches newly
  logic                      lock_q;      // lockout state
  logic [dfs_pkg::NEV-1:0]   live;        // live state vector
  logic [dfs_pkg::NEV-1:0]   prev_q;      // live state last cycle
  logic [dfs_pkg::NEV-1:0]   status_q;    // sticky events
  logic [dfs_pkg::NEV-1:0]   enable_q;    // interrupt enables
  logic [dfs_pkg::NEV-1:0]   clr_mask;    // clear strobe bits
  logic                      bus_hi_det;  // selected bus-high comparator
  logic                      bus_lo_det;  // selected low-bus comparator
  logic                      acc_ok;      // address phase accepted
  logic                      wr_pend_q;   // write data phase pending
  logic [7:0]                wr_addr_q;   // write offset
  logic [31:0]               rdata_d;     // read mux
  logic [31:0]               rdata_q;     // registered read data

  // timers
  dfs_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (hold)
  );

  dfs_ovl_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_ovl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ovl     (ovl)
  );

  assign ovl.above = current_above_level;

  // comparator pick by bus voltage class
  assign bus_hi_det = bus_voltage_class_select ? bus_above_hi_class : bus_above_lo_class;
  assign bus_lo_det = bus_voltage_class_select ? bus_below_hi_class : bus_below_lo_class;

  // undervoltage flag: set below low point, clear only once recovered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_q <= 1'b0;
    end else if (line_below_low) begin
      uv_q <= 1'b1;
    end else if (line_above_high) begin
      uv_q <= 1'b0;
    end
  end

  // plain indication lamps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_q   <= 1'b0;
      regen_q  <= 1'b0;
      opt_in_q <= 1'b0;
    end else begin
      lamp_q   <= current_above_level;
      regen_q  <= regen_flow;
      opt_in_q <= option_fault_in;
    end
  end

  // trip conditions; hold masks the two bus detectors
  always_comb begin
    trip_set                       = '0;
    trip_set[dfs_pkg::TR_BUS_HIGH] = bus_hi_det && !hold;
    trip_set[dfs_pkg::TR_LEG]      = bus_lo_det && !hold;
    trip_set[dfs_pkg::TR_EARTH]    = earth_current;
    trip_set[dfs_pkg::TR_PEAK]     = current_at_peak;
    trip_set[dfs_pkg::TR_SUST]     = ovl.full && current_above_level;
    trip_set[dfs_pkg::TR_THERMAL]  = over_temperature || cooling_air_lost
                                     || precharge_failed;
    trip_set[dfs_pkg::TR_OPTION]   = option_fault_in && option_lockout_select;
  end

  assign rst_all = fault_reset || ctrl_rst_q;

  // trip latches: a present condition beats a reset in the same cycle
  generate
    for (genvar i = 0; i < dfs_pkg::NTRIP; i++) begin : g_trip
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          trip_q[i] <= 1'b0;
        end else begin
          trip_q[i] <= (trip_q[i] && !rst_all) || trip_set[i];
        end
      end
    end
  endgenerate

  assign new_trip = |(trip_set & ~trip_q);

  // catch the strap once after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (!armed_q) begin
      strap_q <= lockout_count_strap;
      armed_q <= 1'b1;
    end
  end

  // count trip events, saturating at two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nfault_q <= 2'h0;
    end else if (rst_all) begin
      nfault_q <= new_trip ? 2'h1 : 2'h0;
    end else if (new_trip && nfault_q != dfs_pkg::LOCK_SECOND) begin
      nfault_q <= nfault_q + 2'h1;
    end
  end

  // lockout on first fault, or on second when strapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b0;
    end else if (rst_all && !new_trip) begin
      lock_q <= 1'b0;
    end else if (new_trip) begin
      if (!strap_q || nfault_q != 2'h0) begin
        lock_q <= 1'b1;
      end
    end
  end

  // live state for status and the fault register
  always_comb begin
    live                       = '0;
    live[dfs_pkg::EV_LINE_LOW] = uv_q;
    live[dfs_pkg::EV_BUS_HIGH] = trip_q[dfs_pkg::TR_BUS_HIGH];
    live[dfs_pkg::EV_LEG]      = trip_q[dfs_pkg::TR_LEG];
    live[dfs_pkg::EV_EARTH]    = trip_q[dfs_pkg::TR_EARTH];
    live[dfs_pkg::EV_PEAK]     = trip_q[dfs_pkg::TR_PEAK];
    live[dfs_pkg::EV_SUST]     = trip_q[dfs_pkg::TR_SUST];
    live[dfs_pkg::EV_THERMAL]  = trip_q[dfs_pkg::TR_THERMAL];
    live[dfs_pkg::EV_OPTION]   = trip_q[dfs_pkg::TR_OPTION] || opt_in_q;
    live[dfs_pkg::EV_REGEN]    = regen_q;
    live[dfs_pkg::EV_LOCKOUT]  = lock_q;
    live[dfs_pkg::EV_HOLD]     = hold;
    live[dfs_pkg::EV_OVL_LAMP] = lamp_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= live;
    end
  end

  // bus address phase accept
  assign acc_ok = hsel && htrans[1] && hready;

  // write data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc_ok && hwrite;
      if (acc_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  assign clr_mask = (wr_pend_q && wr_addr_q == dfs_pkg::OFF_CLEAR) ?
                    hwdata[dfs_pkg::NEV-1:0] : '0;

  // sticky status bits: a rising state wins over a clear
  generate
    for (genvar j = 0; j < dfs_pkg::NEV; j++) begin : g_stat
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          status_q[j] <= 1'b0;
        end else begin
          status_q[j] <= (status_q[j] && !clr_mask[j]) || (live[j] && !prev_q[j]);
        end
      end
    end
  endgenerate

  // enable register and self-clearing fault reset pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q   <= dfs_pkg::ENABLE_RST;
      ctrl_rst_q <= 1'b0;
    end else begin
      ctrl_rst_q <= wr_pend_q && wr_addr_q == dfs_pkg::OFF_CTRL
                    && hwdata[dfs_pkg::CTRL_FAULT_RESET];
      if (wr_pend_q && wr_addr_q == dfs_pkg::OFF_ENABLE) begin
        enable_q <= hwdata[dfs_pkg::NEV-1:0];
      end
    end
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (haddr[7:0])
      dfs_pkg::OFF_STATUS: rdata_d[dfs_pkg::NEV-1:0]   = status_q;
      dfs_pkg::OFF_ENABLE: rdata_d[dfs_pkg::NEV-1:0]   = enable_q;
      dfs_pkg::OFF_FAULTS: rdata_d[dfs_pkg::NEV-1:0]   = live;
      dfs_pkg::OFF_OVLCNT: rdata_d[dfs_pkg::OVL_W-1:0] = ovl.count;
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // read data captured at the end of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // outputs
  assign line_low_flag               = uv_q;
  assign bus_high_fault              = trip_q[dfs_pkg::TR_BUS_HIGH];
  assign leg_conduction_fault        = trip_q[dfs_pkg::TR_LEG];
  assign earth_leak_fault            = trip_q[dfs_pkg::TR_EARTH];
  assign peak_current_trip           = trip_q[dfs_pkg::TR_PEAK];
  assign sustained_overcurrent_fault = trip_q[dfs_pkg::TR_SUST];
  assign thermal_precharge_fault     = trip_q[dfs_pkg::TR_THERMAL];
  assign option_fault                = trip_q[dfs_pkg::TR_OPTION] || opt_in_q;
  assign overcurrent_timer_lamp      = lamp_q;
  assign regen_lamp                  = regen_q;
  assign powerup_hold                = hold;
  assign drive_lockout_lamp          = lock_q;
  assign drive_run_enable            = !lock_q;
  assign irq                         = |(status_q & enable_q);
endmodule
`default_nettype wire

// ### verification/dfs_sensor_model.sv
// comparator model of the drive power stage sensors
`timescale 1ns/100ps
`default_nettype none
module dfs_sensor_model (
  input  wire logic [15:0] line_pm,
  input  wire logic [15:0] bus_v,
  input  wire logic [15:0] cur_pct,
  output logic             line_below_low,
  output logic             line_above_high,
  output logic             bus_above_hi_class,
  output logic             bus_above_lo_class,
  output logic             bus_below_hi_class,
  output logic             bus_below_lo_class,
  output logic             current_at_peak
);
  // line window: below 875 per mille sets, 950 and up clears
  assign line_below_low     = line_pm < 16'h036B;
  assign line_above_high    = line_pm >= 16'h03B6;
  // bus high comparators for 900 V and 450 V classes
  assign bus_above_hi_class = bus_v > 16'h0384;
  assign bus_above_lo_class = bus_v > 16'h01C2;
  // bus collapse comparators for 100 V and 50 V classes
  assign bus_below_hi_class = bus_v < 16'h0064;
  assign bus_below_lo_class = bus_v < 16'h0032;
  // peak current at 180 percent
  assign current_at_peak    = cur_pct >= 16'h00B4;
endmodule
`default_nettype wire

// ### verification/dfs_supervisor_sva.sv
// concurrent checks on the fault supervisor ports
`timescale 1ns/100ps
`default_nettype none
module dfs_supervisor_sva #(
  parameter int HOLD_CYCLES = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic line_below_low,
  input wire logic line_above_high,
  input wire logic bus_above_hi_class,
  input wire logic bus_above_lo_class,
  input wire logic bus_below_hi_class,
  input wire logic bus_below_lo_class,
  input wire logic earth_current,
  input wire logic current_at_peak,
  input wire logic current_above_level,
  input wire logic over_temperature,
  input wire logic cooling_air_lost,
  input wire logic precharge_failed,
  input wire logic regen_flow,
  input wire logic bus_voltage_class_select,
  input wire logic fault_reset,
  input wire logic line_low_flag,
  input wire logic bus_high_fault,
  input wire logic leg_conduction_fault,
  input wire logic earth_leak_fault,
  input wire logic peak_current_trip,
  input wire logic sustained_overcurrent_fault,
  input wire logic overcurrent_timer_lamp,
  input wire logic thermal_precharge_fault,
  input wire logic powerup_hold,
  input wire logic drive_lockout_lamp,
  input wire logic regen_lamp,
  input wire logic drive_run_enable
);
  int hold_cnt_q; // edges since reset release, saturating
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // edges since release, for hold length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_q <= 0;
    end else if (hold_cnt_q < HOLD_CYCLES) begin
      hold_cnt_q <= hold_cnt_q + 1;
    end
  end
  line_set_a: assert property (line_below_low |=> line_low_flag)
    else $error("line low flag missed");
  line_clr_a: assert property (line_above_high && !line_below_low |=> !line_low_flag)
    else $error("line low flag stuck");
  bus_trip_a: assert property ((bus_voltage_class_select ? bus_above_hi_class :
    bus_above_lo_class) && !powerup_hold |=> bus_high_fault) else $error("bus high missed");
  leg_trip_a: assert property ((bus_voltage_class_select ? bus_below_hi_class :
    bus_below_lo_class) && !powerup_hold |=> leg_conduction_fault) else $error("leg missed");
  earth_trip_a: assert property (earth_current |=> earth_leak_fault)
    else $error("earth leak not immediate");
  earth_hold_a: assert property (earth_leak_fault && !fault_reset && !$past(fault_reset) &&
    !$past(hsel && hwrite) && !$past(hsel && hwrite, 2) |=> earth_leak_fault)
    else $error("earth latch dropped");
  peak_trip_a: assert property (current_at_peak |=> peak_current_trip)
    else $error("peak trip missed");
  heat_trip_a: assert property (over_temperature || cooling_air_lost || precharge_failed
    |=> thermal_precharge_fault) else $error("thermal fault missed");
  timer_lamp_a: assert property (current_above_level |=> overcurrent_timer_lamp)
    else $error("timer lamp missed");
  regen_lamp_a: assert property (regen_flow |=> regen_lamp)
    else $error("regen lamp missed");
  hold_mask_a: assert property (powerup_hold |-> !bus_high_fault && !leg_conduction_fault)
    else $error("bus fault during hold");
  hold_len_a: assert property (powerup_hold == (hold_cnt_q < HOLD_CYCLES))
    else $error("hold length wrong");
  run_path_a: assert property (drive_run_enable != drive_lockout_lamp)
    else $error("run path ignores lockout");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  lock_c: cover property ($rose(drive_lockout_lamp));
  sust_c: cover property ($rose(sustained_overcurrent_fault));
  hold_c: cover property ($fell(powerup_hold));
endmodule
bind dfs_supervisor dfs_supervisor_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_dfs_supervisor_sva (.*);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the drive fault supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int TICK = 10; // short overload tick
  localparam int HOLD = 50; // short power-up hold
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq; // bus and interrupt
  logic [31:0] haddr, hwdata, hrdata, rd; // bus address and data
  logic [1:0]  htrans; // transfer kind
  logic [2:0]  hsize, heat; // word size; temperature, air, precharge
  logic [15:0] line_pm, bus_v, cur_pct; // analog quantities
  logic        line_below_low, line_above_high, current_at_peak; // comparators
  logic        bus_above_hi_class, bus_above_lo_class, bus_below_hi_class, bus_below_lo_class;
  logic        earth, above, regen, optin, cls, osel, strap, frst; // sensors, selects
  logic        ll, bh, lg, el, pk, so, lamp, th, of, hold, lock, rl, run; // outputs
  logic        cv, m_bh, m_lg, m_ll; // random class and latch model
  int          err_total, compares, seed, k, v, lv, c0; // counters and scratch
  dfs_sensor_model i_dfs_sensor_model (.*);
  dfs_supervisor #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) i_dfs_supervisor (.*,
    .hready(hreadyout), .earth_current(earth), .current_above_level(above),
    .over_temperature(heat[0]), .cooling_air_lost(heat[1]), .precharge_failed(heat[2]),
    .option_fault_in(optin), .regen_flow(regen), .bus_voltage_class_select(cls),
    .option_lockout_select(osel), .lockout_count_strap(strap), .fault_reset(frst),
    .line_low_flag(ll), .bus_high_fault(bh), .leg_conduction_fault(lg),
    .earth_leak_fault(el), .peak_current_trip(pk), .sustained_overcurrent_fault(so),
    .overcurrent_timer_lamp(lamp), .thermal_precharge_fault(th), .option_fault(of),
    .powerup_hold(hold), .drive_lockout_lamp(lock), .regen_lamp(rl),
    .drive_run_enable(run));
  // free-running bus clock, 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // compares one value and counts it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // prints the verdict and ends the run
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // waits for hready under a bound
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_total++;
      report_and_stop;
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // reads the overload count into rd
  task automatic rdo;
    ahb(1'b0, dfs_pkg::OFF_OVLCNT, 32'h0);
  endtask
  // controller fault reset button pulse
  task automatic clr;
    frst <= 1'b1;
    cyc(1);
    frst <= 1'b0;
    cyc(2);
  endtask
  task automatic pwr;
    hresetn <= 1'b0;
    cyc(5);
    hresetn <= 1'b1;
    cyc(1);
  endtask
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, earth, above, regen, optin, osel, strap, frst} = '0;
    {haddr, hwdata, htrans, heat, cur_pct, m_bh, m_lg, m_ll} = '0;
    {hsize, cls, seed, err_total, compares} = {3'h2, 1'b1, 32'h898f, 64'h0};
    line_pm = 16'h03E8;
    bus_v = 16'h0258;
    pwr();
    rdchk(dfs_pkg::OFF_ENABLE, 32'(dfs_pkg::ENABLE_RST));
    rdchk(8'h40, 32'h0);
    // hold masks bus detectors
    bus_v <= 16'h03B6;
    cyc(20);
    bus_v <= 16'h0014;
    cyc(20);
    chk({bh, lg, hold}, 3'h1);
    bus_v <= 16'h0258;
    cyc(20);
    chk(hold, 1'b0);
    // random levels against latch model
    for (k = 0; k < 40; k++) begin
      cv = 1'($random(seed));
      v = {$random(seed)} % 1001;
      lv = 800 + {$random(seed)} % 200;
      cls <= cv;
      bus_v <= 16'(v);
      line_pm <= 16'(lv);
      cyc(3);
      m_bh = m_bh | (cv ? v > 900 : v > 450);
      m_lg = m_lg | (cv ? v < 100 : v < 50);
      if (lv < 875) m_ll = 1'b1;
      else if (lv >= 950) m_ll = 1'b0;
      chk(bh, m_bh);
      chk(lg, m_lg);
      chk(ll, m_ll);
      chk(lock, m_bh | m_lg);
      if (k % 4 == 3) begin
        bus_v <= cv ? 16'h0258 : 16'h012C;
        clr();
        m_bh = 1'b0;
        m_lg = 1'b0;
      end
    end
    line_pm <= 16'h03E8;
    bus_v <= 16'h0258;
    cls <= 1'b1;
    clr();
    // sticky status, enable and clear around earth leak
    ahb(1'b1, dfs_pkg::OFF_ENABLE, 32'hFFF);
    ahb(1'b1, dfs_pkg::OFF_CLEAR, 32'hFFF);
    cyc(1);
    chk(irq, 1'b0);
    rdchk(dfs_pkg::OFF_ENABLE, 32'hFFF);
    earth <= 1'b1;
    cyc(1);
    earth <= 1'b0;
    cyc(1);
    chk(el, 1'b1);
    cyc(1);
    chk({lock, run, irq}, 3'h5);
    rdchk(dfs_pkg::OFF_STATUS, 32'h208);
    rdchk(dfs_pkg::OFF_FAULTS, 32'h208);
    ahb(1'b1, dfs_pkg::OFF_STATUS, 32'hFFF);
    rdchk(dfs_pkg::OFF_STATUS, 32'h208);
    ahb(1'b1, dfs_pkg::OFF_ENABLE, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    ahb(1'b1, dfs_pkg::OFF_ENABLE, 32'h8);
    cyc(1);
    chk(irq, 1'b1);
    ahb(1'b1, dfs_pkg::OFF_CLEAR, 32'h208);
    cyc(1);
    chk(irq, 1'b0);
    ahb(1'b1, dfs_pkg::OFF_CTRL, 32'h1);
    cyc(2);
    chk({el, lock}, 2'h0);
    // peak below and at threshold, then thermal causes
    cur_pct <= 16'h00B3;
    cyc(3);
    chk(pk, 1'b0);
    for (k = 0; k < 4; k++) begin
      if (k == 0) cur_pct <= 16'h00B4;
      else heat <= 3'(1 << (k - 1));
      cyc(3);
      chk(k == 0 ? pk : th, 1'b1);
      cur_pct <= 16'h0000;
      heat <= 3'h0;
      clr();
      chk({pk, th}, 2'h0);
    end
    // option fault with lockout selection open then closed
    optin <= 1'b1;
    cyc(3);
    chk({of, lock}, 2'h2);
    optin <= 1'b0;
    cyc(3);
    chk(of, 1'b0);
    osel <= 1'b1;
    optin <= 1'b1;
    cyc(3);
    chk(lock, 1'b1);
    optin <= 1'b0;
    cyc(3);
    chk(of, 1'b1);
    clr();
    chk({of, lock}, 2'h0);
    // lamps follow their inputs
    above <= 1'b1;
    regen <= 1'b1;
    cyc(2);
    chk({lamp, rl}, 2'h3);
    above <= 1'b0;
    regen <= 1'b0;
    cyc(20);
    chk({lamp, rl}, 2'h0);
    // overload count up, down, kept over fault reset
    rdchk(dfs_pkg::OFF_OVLCNT, 32'h0);
    above <= 1'b1;
    cyc(300);
    rdo();
    chk(rd >= 29 && rd <= 31, 1'b1);
    chk(so, 1'b0);
    cyc(350);
    chk(so, 1'b1);
    rdchk(dfs_pkg::OFF_OVLCNT, 32'h3C);
    above <= 1'b0;
    cyc(100);
    rdo();
    c0 = int'(rd);
    chk(c0 >= 49 && c0 <= 51, 1'b1);
    clr();
    chk(so, 1'b0);
    rdo();
    chk(int'(rd) <= c0 && int'(rd) + 1 >= c0, 1'b1);
    above <= 1'b1;
    cyc(70);
    chk(so, 1'b0);
    cyc(80);
    chk(so, 1'b1);
    // power loss clears timer; strap wants second fault
    above <= 1'b0;
    strap <= 1'b1;
    pwr();
    rdchk(dfs_pkg::OFF_OVLCNT, 32'h0);
    earth <= 1'b1;
    cyc(1);
    earth <= 1'b0;
    cyc(2);
    chk({el, lock}, 2'h2);
    cur_pct <= 16'h00B4;
    cyc(1);
    cur_pct <= 16'h0000;
    cyc(2);
    chk({pk, lock, run}, 3'h6);
    report_and_stop;
  end
endmodule
`default_nettype wire
